// ===== inc/sar_adc_pkg.sv
// Constants shared by the successive-approximation converter sequencer.
package sar_adc_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] OFS_CTRL0 = 8'h00;
  localparam logic [7:0] OFS_CTRL1 = 8'h04;
  localparam logic [7:0] OFS_RES_HIGH = 8'h08;
  localparam logic [7:0] OFS_RES_LOW = 8'h0c;
  localparam logic [7:0] OFS_RES_HIGH_ALT = 8'h10;
  localparam logic [7:0] OFS_RES_LOW_ALT = 8'h14;
  localparam logic [7:0] OFS_PFLAG1 = 8'h18;
  localparam logic [7:0] OFS_PENABLE1 = 8'h1c;
  localparam logic [7:0] OFS_INTCTRL = 8'h20;

  // Field positions in converter_control_0.
  localparam int ENABLE_BIT = 0;
  localparam int GO_BIT = 1;
  localparam int CHSEL_LSB = 2;
  localparam int CHSEL_MSB = 6;
  // Field positions in converter_control_1.
  localparam int PREF_LSB = 0;
  localparam int PREF_MSB = 1;
  localparam int CLKSEL_LSB = 4;
  localparam int CLKSEL_MSB = 6;
  localparam int JUSTIFY_BIT = 7;
  // Field positions in the flag, enable and interrupt control registers.
  localparam int DONE_FLAG_BIT = 0;
  localparam int DONE_IE_BIT = 0;
  localparam int PERIPH_IE_BIT = 0;
  localparam int GLOBAL_IE_BIT = 1;

  // Reset values of the registers.
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [9:0] RST_RESULT = 10'h000;

  // Conversion clock select codes; bit pattern x11 selects the RC oscillator.
  localparam logic [2:0] CLK_DIV2 = 3'h0;
  localparam logic [2:0] CLK_DIV4 = 3'h4;
  localparam logic [2:0] CLK_DIV8 = 3'h1;
  localparam logic [2:0] CLK_DIV16 = 3'h5;
  localparam logic [2:0] CLK_DIV32 = 3'h2;
  localparam logic [2:0] CLK_DIV64 = 3'h6;
  localparam logic [1:0] CLK_RC_LOW = 2'h3;

  // Half conversion-clock period in core clock cycles, per divided option.
  localparam logic [5:0] HALF_DIV2 = 6'h01;
  localparam logic [5:0] HALF_DIV4 = 6'h02;
  localparam logic [5:0] HALF_DIV8 = 6'h04;
  localparam logic [5:0] HALF_DIV16 = 6'h08;
  localparam logic [5:0] HALF_DIV32 = 6'h10;
  localparam logic [5:0] HALF_DIV64 = 6'h20;

  // Conversion length: 11.5 periods are 23 half periods; first decision after half 3.
  localparam logic [4:0] HALF_TOTAL = 5'h17;
  localparam logic [4:0] HALF_FIRST_BIT = 5'h03;
  localparam int RESULT_W = 10;
  // One instruction cycle of core clocks, the extra delay before an RC conversion.
  localparam logic [2:0] INSTR_CYCLES = 3'h4;

  // Positive reference select codes.
  localparam logic [1:0] PREF_SUPPLY = 2'h0;
  localparam logic [1:0] PREF_RESERVED = 2'h1;
  localparam logic [1:0] PREF_EXT_PIN = 2'h2;
  localparam logic [1:0] PREF_FIXED = 2'h3;

  // Channel select codes for internal sources; 8..19 and 0..4 are pins.
  localparam logic [4:0] CH_FIXED_REF = 5'h1f;
  localparam logic [4:0] CH_TEMP = 5'h1d;
  localparam logic [4:0] CH_NEG_REF = 5'h1b;
  localparam logic [4:0] CH_POS_REF = 5'h1a;
  localparam logic [4:0] CH_PIN_HI_MAX = 5'h13;
  localparam logic [4:0] CH_PIN_HI_MIN = 5'h08;
  localparam logic [4:0] CH_PIN_LO_MAX = 5'h04;

  // Sequencer states.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RC_WAIT = 2'b01,
    ST_CONV = 2'b10
  } seq_state_e;

endpackage

// ===== hw/sar_adc_sequencer.sv
// Sequencer and register file of a 10-bit successive-approximation converter.
`timescale 1ns/1ps

module sar_adc_sequencer
  import sar_adc_pkg::*;
(
  // Clock and synchronous reset.
  input wire logic core_clk,
  input wire logic srst,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Processor state and dedicated RC oscillator half-period tick.
  input wire logic sleep_active,
  input wire logic rc_half_tick,
  // Analog front end.
  input wire logic cmp_above,
  output logic [9:0] dac_code,
  output logic [4:0] mux_channel,
  output logic mux_connect,
  output logic [1:0] vref_pos_select,
  output logic hold_sample,
  output logic converter_powered,
  // Processor event outputs.
  output logic wake_pulse,
  output logic vector_pulse
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.
  logic enable_reg;
  logic go_reg;
  logic [4:0] channel_reg;
  logic justify_reg;
  logic [2:0] clk_sel_reg;
  logic [1:0] pref_reg;
  logic [9:0] result_reg;
  logic done_flag_reg;
  logic done_ie_reg;
  logic periph_ie_reg;
  logic global_ie_reg;
  logic powered_reg;
  seq_state_e state_reg;
  logic [5:0] div_cnt_reg;
  logic [4:0] half_cnt_reg;
  logic [2:0] wait_cnt_reg;
  logic [3:0] bit_ptr_reg;
  logic [9:0] sar_reg;
  logic [9:0] decided_reg;
  logic last_bit_reg;
  logic [9:0] filled;
  logic [5:0] half_len;
  logic is_rc;
  logic half_tick;
  logic wr_en;
  logic rd_en;
  logic setup_phase;
  logic hit_ctrl0;
  logic start_req;
  logic sw_abort;
  logic sleep_abort;
  logic finish;
  logic load_result;
  logic decide;
  logic [31:0] rd_value;
  logic rd_mapped;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode. Each access takes one wait-free cycle after setup.
  assign setup_phase = psel && !penable;
  assign wr_en = psel && penable && pready && pwrite;
  assign rd_en = psel && penable && pready && !pwrite;
  assign hit_ctrl0 = wr_en && (paddr == OFS_CTRL0);

  // Ready rises for exactly the access cycle of each transfer.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pready <= 1'b0;
    end else begin
      pready <= setup_phase && !pready;
    end
  end

  // Read mux; both result aliases decode to the same storage.
  always_comb begin
    rd_value = 32'h0000_0000;
    rd_mapped = 1'b1;
    case (paddr)
      OFS_CTRL0: rd_value = {25'h0, channel_reg, go_reg, enable_reg};
      OFS_CTRL1: rd_value = {24'h0, justify_reg, clk_sel_reg, 2'h0, pref_reg};
      OFS_RES_HIGH, OFS_RES_HIGH_ALT: begin
        rd_value = justify_reg ? {30'h0, result_reg[9:8]} : {24'h0, result_reg[9:2]};
      end
      OFS_RES_LOW, OFS_RES_LOW_ALT: begin
        rd_value = justify_reg ? {24'h0, result_reg[7:0]} : {24'h0, result_reg[1:0], 6'h00};
      end
      OFS_PFLAG1: rd_value = {31'h0, done_flag_reg};
      OFS_PENABLE1: rd_value = {31'h0, done_ie_reg};
      OFS_INTCTRL: rd_value = {30'h0, global_ie_reg, periph_ie_reg};
      default: rd_mapped = 1'b0;
    endcase
  end

  // Read data and error answer are captured at setup, valid during access.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup_phase && !pready) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_value;
      pslverr <= !rd_mapped;
    end else begin
      pslverr <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Start, abort and completion decisions.
  assign is_rc = (clk_sel_reg[1:0] == CLK_RC_LOW);
  // A write that also turns the converter off never starts one.
  assign start_req = hit_ctrl0 && pwdata[GO_BIT] && pwdata[ENABLE_BIT] && enable_reg
    && (state_reg == ST_IDLE);
  assign sw_abort = hit_ctrl0 && (state_reg != ST_IDLE) && (!pwdata[GO_BIT] || !pwdata[ENABLE_BIT]);
  assign sleep_abort = sleep_active && !is_rc && (state_reg != ST_IDLE);
  assign finish = (state_reg == ST_CONV) && half_tick && (half_cnt_reg == HALF_TOTAL - 5'h01);
  assign load_result = finish || sw_abort || sleep_abort;
  assign decide = (state_reg == ST_CONV) && half_tick && half_cnt_reg[0]
    && (half_cnt_reg >= HALF_FIRST_BIT) && (bit_ptr_reg < 4'(RESULT_W));

  // Control register 0 fields. Go clears on completion or any abort.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      enable_reg <= 1'b0;
      go_reg <= 1'b0;
      channel_reg <= RST_BYTE[4:0];
    end else begin
      if (hit_ctrl0) begin
        enable_reg <= pwdata[ENABLE_BIT];
        channel_reg <= pwdata[CHSEL_MSB:CHSEL_LSB];
      end
      if (load_result) begin
        go_reg <= 1'b0;
      end else if (start_req) begin
        go_reg <= 1'b1;
      end
    end
  end

  // Control register 1 fields and the interrupt enables.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      justify_reg <= 1'b0;
      clk_sel_reg <= RST_BYTE[2:0];
      pref_reg <= RST_BYTE[1:0];
      done_ie_reg <= 1'b0;
      periph_ie_reg <= 1'b0;
      global_ie_reg <= 1'b0;
    end else if (wr_en) begin
      if (paddr == OFS_CTRL1) begin
        justify_reg <= pwdata[JUSTIFY_BIT];
        clk_sel_reg <= pwdata[CLKSEL_MSB:CLKSEL_LSB];
        pref_reg <= pwdata[PREF_MSB:PREF_LSB];
      end
      if (paddr == OFS_PENABLE1) begin
        done_ie_reg <= pwdata[DONE_IE_BIT];
      end
      if (paddr == OFS_INTCTRL) begin
        periph_ie_reg <= pwdata[PERIPH_IE_BIT];
        global_ie_reg <= pwdata[GLOBAL_IE_BIT];
      end
    end
  end

  // Done flag: hardware only sets it, and a set beats a software clear.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      done_flag_reg <= 1'b0;
    end else if (finish) begin
      done_flag_reg <= 1'b1;
    end else if (wr_en && paddr == OFS_PFLAG1) begin
      done_flag_reg <= pwdata[DONE_FLAG_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Half-period tick: a divider on the core clock, or the RC oscillator tick.
  always_comb begin
    case (clk_sel_reg)
      CLK_DIV2: half_len = HALF_DIV2;
      CLK_DIV4: half_len = HALF_DIV4;
      CLK_DIV8: half_len = HALF_DIV8;
      CLK_DIV16: half_len = HALF_DIV16;
      CLK_DIV32: half_len = HALF_DIV32;
      CLK_DIV64: half_len = HALF_DIV64;
      default: half_len = HALF_DIV2;
    endcase
  end

  assign half_tick = is_rc ? rc_half_tick : (div_cnt_reg == half_len - 6'h01);

  // Divider restarts with every conversion so the first half is full length.
  always_ff @(posedge core_clk) begin
    if (srst || state_reg != ST_CONV || half_tick) begin
      div_cnt_reg <= 6'h00;
    end else begin
      div_cnt_reg <= div_cnt_reg + 6'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state and counters.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_reg <= ST_IDLE;
      half_cnt_reg <= 5'h00;
      wait_cnt_reg <= 3'h0;
    end else if (load_result) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          half_cnt_reg <= 5'h00;
          wait_cnt_reg <= INSTR_CYCLES - 3'h1;
          if (start_req) begin
            state_reg <= is_rc ? ST_RC_WAIT : ST_CONV;
          end
        end
        ST_RC_WAIT: begin
          wait_cnt_reg <= wait_cnt_reg - 3'h1;
          if (wait_cnt_reg == 3'h0) begin
            state_reg <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (half_tick) begin
            half_cnt_reg <= half_cnt_reg + 5'h01;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Successive approximation: keep the trial bit if the input is above it.
  always_ff @(posedge core_clk) begin
    if (srst || state_reg == ST_IDLE) begin
      sar_reg <= 10'h200;
      decided_reg <= 10'h000;
      bit_ptr_reg <= 4'(RESULT_W - 1);
      last_bit_reg <= 1'b0;
    end else if (decide) begin
      sar_reg[bit_ptr_reg] <= cmp_above;
      if (bit_ptr_reg != 4'h0) begin
        sar_reg[bit_ptr_reg - 4'h1] <= 1'b1;
      end
      decided_reg[bit_ptr_reg] <= 1'b1;
      last_bit_reg <= cmp_above;
      bit_ptr_reg <= bit_ptr_reg - 4'h1;
    end
  end

  // Undecided bits repeat the last decided one, for a partial result.
  genvar gi;
  generate
    for (gi = 0; gi < RESULT_W; gi++) begin : g_fill
      assign filled[gi] = decided_reg[gi] ? sar_reg[gi] : last_bit_reg;
    end
  endgenerate

  // Result storage; hardware loads win over software writes to either alias.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      result_reg <= RST_RESULT;
    end else if (load_result) begin
      result_reg <= filled;
    end else if (wr_en && (paddr == OFS_RES_HIGH || paddr == OFS_RES_HIGH_ALT)) begin
      if (justify_reg) begin
        result_reg[9:8] <= pwdata[1:0];
      end else begin
        result_reg[9:2] <= pwdata[7:0];
      end
    end else if (wr_en && (paddr == OFS_RES_LOW || paddr == OFS_RES_LOW_ALT)) begin
      if (justify_reg) begin
        result_reg[7:0] <= pwdata[7:0];
      end else begin
        result_reg[1:0] <= pwdata[7:6];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power state: sleep may turn the converter off while enable stays set.
  always_ff @(posedge core_clk) begin
    if (srst || !sleep_active) begin
      powered_reg <= 1'b1;
    end else if (!is_rc) begin
      powered_reg <= 1'b0;
    end else if (finish && !done_ie_reg) begin
      powered_reg <= 1'b0;
    end
  end

  // Analog controls and event pulses, all registered.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      dac_code <= 10'h000;
      mux_channel <= 5'h00;
      mux_connect <= 1'b0;
      vref_pos_select <= PREF_SUPPLY;
      hold_sample <= 1'b0;
      converter_powered <= 1'b0;
      wake_pulse <= 1'b0;
      vector_pulse <= 1'b0;
    end else begin
      dac_code <= sar_reg;
      mux_channel <= channel_reg;
      mux_connect <= enable_reg && powered_reg;
      vref_pos_select <= pref_reg;
      hold_sample <= (state_reg == ST_CONV);
      converter_powered <= enable_reg && powered_reg;
      wake_pulse <= finish && sleep_active && done_ie_reg;
      vector_pulse <= finish && sleep_active && done_ie_reg && global_ie_reg
        && periph_ie_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.
  sequence s_start;
    start_req && !is_rc;
  endsequence

  sequence s_rc_start;
    start_req && is_rc;
  endsequence

  a_done_sets_flag: assert property (@(posedge core_clk) disable iff (srst)
    finish |=> done_flag_reg && !go_reg)
    else $error("done flag not set or go not cleared after completion");

  a_flag_not_hw_cleared: assert property (@(posedge core_clk) disable iff (srst)
    $fell(done_flag_reg) |-> $past(wr_en) && $past(paddr) == OFS_PFLAG1)
    else $error("done flag cleared without a software write");

  a_mux_off_disabled: assert property (@(posedge core_clk) disable iff (srst)
    !enable_reg |=> !mux_connect)
    else $error("multiplexer connected while converter disabled");

  a_rc_start_delay: assert property (@(posedge core_clk) disable iff (srst)
    s_rc_start ##1 !load_result [*4] |=> state_reg == ST_CONV && $past(state_reg) == ST_RC_WAIT
      && $past(state_reg, 4) == ST_RC_WAIT)
    else $error("RC conversion did not wait one instruction cycle");

  a_fast_conv_len: assert property (@(posedge core_clk) disable iff (srst)
    s_start ##0 (clk_sel_reg == CLK_DIV2) ##1 (!sw_abort && !sleep_abort) [*8]
    |-> ##15 finish)
    else $error("conversion at system clock over two did not take 23 cycles");

  a_abort_clears_go: assert property (@(posedge core_clk) disable iff (srst)
    sw_abort |=> !go_reg && state_reg == ST_IDLE && result_reg == $past(filled))
    else $error("abort did not load the partial result");

  a_sleep_abort: assert property (@(posedge core_clk) disable iff (srst)
    sleep_abort |=> state_reg == ST_IDLE ##1 !converter_powered)
    else $error("sleep with divided clock did not abort and power down");

  a_enable_kept: assert property (@(posedge core_clk) disable iff (srst)
    $fell(powered_reg) |-> $stable(enable_reg))
    else $error("power down changed the enable bit");

  a_wake_on_done: assert property (@(posedge core_clk) disable iff (srst)
    finish && sleep_active && done_ie_reg |=> wake_pulse)
    else $error("no wake after completion in sleep");

  a_start_needs_enable: assert property (@(posedge core_clk) disable iff (srst)
    $rose(go_reg) |-> $past(enable_reg))
    else $error("conversion started with converter disabled");

  a_right_justify: assert property (@(posedge core_clk) disable iff (srst)
    rd_en && justify_reg && (paddr == OFS_RES_HIGH) |-> prdata[7:2] == 6'h00)
    else $error("upper bits of right justified high result not zero");

endmodule // sar_adc_sequencer

// ===== dv/analog_side_model.sv
// Model of the analog inputs and the dedicated RC oscillator beside the converter.
`timescale 1ns/1ps
module analog_side_model #(
  parameter int RC_HALF = 3
) (
  // Clock.
  input wire logic core_clk,
  // Converter side.
  input wire logic [9:0] dac_code,
  input wire logic mux_connect,
  input wire logic [9:0] level,
  output logic cmp_above,
  output logic rc_half_tick
);
  logic [3:0] rc_cnt = 4'h0;
  logic flip = 1'b0;
  // The RC oscillator runs free; a floating input makes the comparator wander.
  always_ff @(posedge core_clk) begin
    flip <= ~flip;
    rc_cnt <= (rc_cnt == 4'(RC_HALF - 1)) ? 4'h0 : rc_cnt + 4'h1;
  end
  // A connected source compares its level against the trial code.
  assign cmp_above = mux_connect ? (level >= dac_code) : flip;
  assign rc_half_tick = (rc_cnt == 4'h0);
endmodule // analog_side_model

// ===== dv/tb_top.sv
// Self-checking testbench of the converter sequencer.
`timescale 1ns/1ps
module tb_top;
  import sar_adc_pkg::*;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, rc_half_tick, cmp_above, err;
  logic sleep_active = 1'b0;
  logic [9:0] dac_code;
  logic [9:0] level = 10'h000;
  logic [4:0] mux_channel;
  logic mux_connect, hold_sample, converter_powered, wake_pulse, vector_pulse;
  logic [1:0] vref_pos_select;
  logic [31:0] rd;
  int n_mismatch = 0;
  int total_checks = 0;
  int hold_cnt = 0;
  int wake_cnt = 0;
  int vec_cnt = 0;

  ////////////////////////////////////////
  // Clock, design and analog side.
  always #20 core_clk = ~core_clk;
  sar_adc_sequencer dut (.core_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .sleep_active, .rc_half_tick, .cmp_above, .dac_code,
    .mux_channel, .mux_connect, .vref_pos_select, .hold_sample, .converter_powered,
    .wake_pulse, .vector_pulse);
  analog_side_model model (.core_clk, .dac_code, .mux_connect, .level, .cmp_above,
    .rc_half_tick);
  // Count converting cycles and processor event pulses.
  always @(posedge core_clk) begin
    if (hold_sample === 1'b1) hold_cnt <= hold_cnt + 1;
    if (wake_pulse === 1'b1) wake_cnt <= wake_cnt + 1;
    if (vector_pulse === 1'b1) vec_cnt <= vec_cnt + 1;
  end

  ////////////////////////////////////////
  // Shared tasks.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    if (n_mismatch == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // One APB transfer; the request holds until pready is sampled high.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
    if (n >= 20) begin
      n_mismatch++;
      stop_test();
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      xfer(1'b0, OFS_CTRL0, 32'h0);
      n++;
    end while (rd[GO_BIT] !== 1'b0 && n < 1000);
    if (n >= 1000) begin
      n_mismatch++;
      stop_test();
    end
  endtask
  // Set clock and format, enable, clear the flag, let the input settle, then start.
  task automatic start(input logic [2:0] cs, input logic fmt);
    xfer(1'b1, OFS_CTRL1, {24'h0, fmt, cs, 4'h0});
    xfer(1'b1, OFS_CTRL0, 32'h1);
    xfer(1'b1, OFS_PFLAG1, 32'h0);
    repeat (8) @(posedge core_clk);
    hold_cnt = 0;
    xfer(1'b1, OFS_CTRL0, 32'h3);
  endtask

  ////////////////////////////////////////
  // Scenarios.
  task automatic t_regs();
    logic [7:0] regs [9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20};
    foreach (regs[i]) rdc(regs[i], 32'h0);
    chk(32'(mux_connect), 32'h0);
    xfer(1'b1, 8'h24, 32'hff);
    chk(32'(err), 32'h1);
    rdc(8'h24, 32'h0);
    xfer(1'b1, OFS_RES_HIGH_ALT, 32'h5a);
    rdc(OFS_RES_HIGH, 32'h5a);
    xfer(1'b1, OFS_RES_LOW, 32'ha5);
    rdc(OFS_RES_LOW_ALT, 32'h80);
  endtask
  task automatic t_mux();
    logic [4:0] channel_select [8] = '{5'h1f, 5'h1d, 5'h1b, 5'h1a, 5'h13, 5'h08, 5'h04, 5'h00};
    foreach (channel_select[i]) begin
      xfer(1'b1, OFS_CTRL0, {25'h0, channel_select[i], 2'b01});
      @(posedge core_clk);
      chk(32'(mux_channel), 32'(channel_select[i]));
      chk(32'(mux_connect), 32'h1);
    end
    xfer(1'b1, OFS_CTRL0, 32'h2);
    @(posedge core_clk);
    chk(32'(mux_connect), 32'h0);
    rdc(OFS_CTRL0, 32'h0);
    for (int p = 0; p < 4; p++) begin
      xfer(1'b1, OFS_CTRL1, 32'(p));
      @(posedge core_clk);
      chk(32'(vref_pos_select), 32'(p));
    end
  endtask
  task automatic t_conv(input logic fmt, input logic [9:0] lv);
    level <= lv;
    start(CLK_DIV2, fmt);
    wait_idle();
    chk(32'(dac_code), 32'h200);
    rdc(OFS_PFLAG1, 32'h1);
    rdc(OFS_RES_HIGH, fmt ? 32'(lv[9:8]) : 32'(lv[9:2]));
    rdc(OFS_RES_LOW_ALT, fmt ? 32'(lv[7:0]) : {24'h0, lv[1:0], 6'h00});
    repeat (40) @(posedge core_clk);
    rdc(OFS_PFLAG1, 32'h1);
    xfer(1'b1, OFS_PFLAG1, 32'h0);
    rdc(OFS_PFLAG1, 32'h0);
  endtask
  task automatic t_timing();
    logic [2:0] cs [6] = '{CLK_DIV2, CLK_DIV4, CLK_DIV8, CLK_DIV16, CLK_DIV32, CLK_DIV64};
    int h [6] = '{1, 2, 4, 8, 16, 32};
    int c [6];
    foreach (cs[i]) begin
      start(cs[i], 1'b1);
      wait_idle();
      c[i] = hold_cnt;
      chk(32'(c[i]), 32'(23 * h[i]));
      if (i > 0) chk(32'(c[i] - c[i-1]), 32'(23 * (h[i] - h[i-1])));
    end
  endtask
  task automatic t_abort();
    level <= 10'h2a5;
    start(CLK_DIV64, 1'b1);
    repeat (150) @(posedge core_clk);
    xfer(1'b1, OFS_CTRL0, 32'h1);
    rdc(OFS_RES_HIGH, 32'h3);
    rdc(OFS_RES_LOW, 32'hff);
    rdc(OFS_PFLAG1, 32'h0);
    start(CLK_DIV64, 1'b0);
    repeat (20) @(posedge core_clk);
    srst <= 1'b1;
    @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    chk(32'(hold_sample), 32'h0);
    rdc(OFS_CTRL0, 32'h0);
  endtask
  task automatic t_sleep(input logic ie, input logic [2:0] cs);
    xfer(1'b1, OFS_PENABLE1, 32'(ie));
    xfer(1'b1, OFS_INTCTRL, 32'h3);
    level <= 10'h155;
    wake_cnt = 0;
    vec_cnt = 0;
    start(cs, 1'b1);
    sleep_active <= 1'b1;
    repeat (200) @(posedge core_clk);
    chk(32'(wake_cnt), 32'(ie && cs[1:0] == CLK_RC_LOW));
    chk(32'(vec_cnt), 32'(ie && cs[1:0] == CLK_RC_LOW));
    chk(32'(converter_powered), 32'(ie && cs[1:0] == CLK_RC_LOW));
    rdc(OFS_CTRL0, 32'h1);
    rdc(OFS_PFLAG1, 32'(cs[1:0] == CLK_RC_LOW));
    sleep_active <= 1'b0;
  endtask

  ////////////////////////////////////////
  // Main sequence.
  initial begin
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    t_regs();
    t_mux();
    t_conv(1'b1, 10'h2c7);
    t_conv(1'b0, 10'h19e);
    t_timing();
    t_abort();
    t_sleep(1'b1, 3'h3);
    t_sleep(1'b0, 3'h7);
    t_sleep(1'b1, CLK_DIV64);
    stop_test();
  end
endmodule // tb_top
